// ---- core/cal_pkg.sv ----
// Constants and types for the conversion and limit alert control block
package cal_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  // Register byte addresses (configuration index 1h, limits 2h..5h)
  localparam logic [7:0] ADDR_TEMP = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_HIGH1 = 8'h08;
  localparam logic [7:0] ADDR_LOW1 = 8'h0c;
  localparam logic [7:0] ADDR_HIGH2 = 8'h10;
  localparam logic [7:0] ADDR_LOW2 = 8'h14;
  // Configuration field positions
  localparam int RATE_LSB = 13;
  localparam int SINGLE_BIT = 12;
  localparam int SHUT_BIT = 11;
  localparam int CH1_HIGH_BIT = 10;
  localparam int CH1_LOW_BIT = 9;
  localparam int CH1_MODE_BIT = 8;
  localparam int CH1_POL_BIT = 7;
  localparam int CH2_HIGH_BIT = 6;
  localparam int CH2_LOW_BIT = 5;
  localparam int CH2_MODE_BIT = 4;
  localparam int CH2_POL_BIT = 3;
  localparam logic [2:0] RATE_RESET = 3'h5;
  localparam logic [13:0] HIGH_RESET = 14'h1fff;
  localparam logic [13:0] LOW_RESET = 14'h2000;
  // Tick divider: one enable per millisecond
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_NS / 10;
  // Conversion periods in ms
  localparam int unsigned PERIOD_MS_0 = 15;
  localparam int unsigned PERIOD_MS_1 = 50;
  localparam int unsigned PERIOD_MS_2 = 100;
  localparam int unsigned PERIOD_MS_3 = 250;
  localparam int unsigned PERIOD_MS_4 = 500;
  localparam int unsigned PERIOD_MS_5 = 1000;
  localparam int unsigned PERIOD_MS_6 = 4000;
  localparam int unsigned PERIOD_MS_7 = 16000;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_WAIT = 2'b01,
    CAL_CONV = 2'b11
  } cal_state_t;
endpackage

// ---- core/cal_limit_channel.sv ----
// One limit comparison channel: window or threshold with hysteresis
`timescale 1ns/10ps
module cal_limit_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Settings
  input wire logic mode_select,
  input wire logic output_polarity,
  input wire logic signed [13:0] high_limit,
  input wire logic signed [13:0] low_limit,
  // Events
  input wire logic result_valid,
  input wire logic signed [13:0] result,
  input wire logic flag_read,
  // Flags and pin
  output logic high_flag,
  output logic low_flag,
  output logic warning_output
);
  typedef struct packed {
    logic high;
    logic low;
    logic pin;
  } cal_ch_state_t;
  cal_ch_state_t st;
  cal_ch_state_t next_st;
  logic above;
  logic below;
  assign above = result > high_limit;
  assign below = result < low_limit;
  always_comb begin
    next_st = st;
    if (mode_select) begin
      // Threshold: only conversion ends move the flag, reads do not
      if (result_valid && above) begin
        next_st.high = 1'b1;
      end else if (result_valid && below) begin
        next_st.high = 1'b0;
      end
      next_st.low = 1'b0;
    end else begin
      // Window: sticky until read; a new event wins over the read clear
      if (flag_read) begin
        next_st.high = 1'b0;
        next_st.low = 1'b0;
      end
      if (result_valid && above) begin
        next_st.high = 1'b1;
      end
      if (result_valid && below) begin
        next_st.low = 1'b1;
      end
    end
    next_st.pin = (next_st.high | next_st.low) ~^ output_polarity;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st <= '{high: 1'b0, low: 1'b0, pin: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  assign high_flag = st.high;
  assign low_flag = st.low;
  assign warning_output = st.pin;
endmodule

// ---- core/cal_control.sv ----
// Conversion timing, configuration register and limit alerts behind an AHB-Lite slave
//
// Operation
// - Rate field bits 15:13, reset 5h, sets continuous period only.
// - Shutdown bit 11: 0 continuous, 1 shutdown with single-shot only.
// - Single-shot bit 12 in shutdown starts one conversion, then back to shutdown.
// - Single-shot bit always reads zero.
// - Channel-1 high flag bit 10 set when result exceeds high limit 1.
// - Channel-1 low flag bit 9 set in window mode when result below low limit.
// - Channel-1 mode bit 8 zero: limits form a window setting both flags.
// - Window-mode flags stay set until a configuration read clears them.
// - Threshold mode: high flag sets above high, clears below low limit.
// - Threshold mode: low flag always reads zero.
// - Threshold flags change only at conversion end, reads do not clear.
// - Channel-1 polarity bit 7: first alert active low at 0, high at 1.
// - Channel-2 high flag bit 6 set when result exceeds high limit 2.
// - Channel-2 low flag bit 5 as channel 1, zero in threshold mode.
// - Channel-2 mode bit 4 selects window or threshold, like channel 1.
// - Channel-2 polarity bit 3: second alert active low at 0, high at 1.
// - Any configuration write aborts the conversion and applies new settings at once.
// - Results and limits compare as signed 14-bit twos complement.
`timescale 1ns/10ps
module cal_control #(
  parameter int unsigned TICK_LEN = cal_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [13:0] conv_result,
  // Alert pins
  output logic first_warning_output,
  output logic second_warning_output
);
  import cal_pkg::*;

  typedef struct packed {
    cal_state_t fsm;
    logic [2:0] rate_select;
    logic shutdown_select;
    logic ch1_mode_select;
    logic ch1_output_polarity;
    logic ch2_mode_select;
    logic ch2_output_polarity;
    logic [13:0] high1;
    logic [13:0] low1;
    logic [13:0] high2;
    logic [13:0] low2;
    logic [13:0] temp;
    logic [16:0] tick_cnt;
    logic [13:0] ms_cnt;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic start;
  } cal_state_pkt_t;
  cal_state_pkt_t st;
  cal_state_pkt_t next_st;

  logic ch1_high_flag;
  logic ch1_low_flag;
  logic ch2_high_flag;
  logic ch2_low_flag;
  logic tick;
  logic take;
  logic cfg_write;
  logic cfg_read;
  logic result_valid;
  logic [15:0] cfg_word;

  // Period in ms for a rate code
  function automatic logic [13:0] period_ms(input logic [2:0] code);
    unique case (code)
      3'h0: period_ms = 14'(PERIOD_MS_0);
      3'h1: period_ms = 14'(PERIOD_MS_1);
      3'h2: period_ms = 14'(PERIOD_MS_2);
      3'h3: period_ms = 14'(PERIOD_MS_3);
      3'h4: period_ms = 14'(PERIOD_MS_4);
      3'h5: period_ms = 14'(PERIOD_MS_5);
      3'h6: period_ms = 14'(PERIOD_MS_6);
      3'h7: period_ms = 14'(PERIOD_MS_7);
    endcase
  endfunction

  assign take = hsel && hready && htrans[1];
  assign cfg_write = st.ap_valid && st.ap_write && (st.ap_addr == ADDR_CONFIG);
  // Read clear acts when the address phase is accepted
  assign cfg_read = take && !hwrite && (haddr == ADDR_CONFIG);
  assign tick = (st.tick_cnt == 17'(TICK_LEN - 1));
  // Result arriving in the write cycle is an aborted conversion and is dropped
  assign result_valid = conv_done && (st.fsm == CAL_CONV) && !cfg_write;

  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[RATE_LSB +: 3] = st.rate_select;
    cfg_word[SINGLE_BIT] = 1'b0;
    cfg_word[SHUT_BIT] = st.shutdown_select;
    cfg_word[CH1_HIGH_BIT] = ch1_high_flag;
    cfg_word[CH1_LOW_BIT] = ch1_low_flag;
    cfg_word[CH1_MODE_BIT] = st.ch1_mode_select;
    cfg_word[CH1_POL_BIT] = st.ch1_output_polarity;
    cfg_word[CH2_HIGH_BIT] = ch2_high_flag;
    cfg_word[CH2_LOW_BIT] = ch2_low_flag;
    cfg_word[CH2_MODE_BIT] = st.ch2_mode_select;
    cfg_word[CH2_POL_BIT] = st.ch2_output_polarity;
  end

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.ap_valid = take;
    if (take) begin
      next_st.ap_write = hwrite;
      next_st.ap_addr = haddr;
      unique case (haddr)
        ADDR_TEMP: next_st.rdata = {16'h0000, st.temp, 2'b00};
        ADDR_CONFIG: next_st.rdata = {16'h0000, cfg_word};
        ADDR_HIGH1: next_st.rdata = {16'h0000, st.high1, 2'b00};
        ADDR_LOW1: next_st.rdata = {16'h0000, st.low1, 2'b00};
        ADDR_HIGH2: next_st.rdata = {16'h0000, st.high2, 2'b00};
        ADDR_LOW2: next_st.rdata = {16'h0000, st.low2, 2'b00};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Millisecond divider
    next_st.tick_cnt = tick ? 17'h00000 : st.tick_cnt + 17'h00001;
    if (st.ap_valid && st.ap_write) begin
      unique case (st.ap_addr)
        ADDR_HIGH1: next_st.high1 = hwdata[15:2];
        ADDR_LOW1: next_st.low1 = hwdata[15:2];
        ADDR_HIGH2: next_st.high2 = hwdata[15:2];
        ADDR_LOW2: next_st.low2 = hwdata[15:2];
        default: ;
      endcase
    end
    if (result_valid) begin
      next_st.temp = conv_result;
    end
    // Conversion sequencing
    unique case (st.fsm)
      CAL_IDLE: begin
        // Continuous mode starts right after reset
        if (!st.shutdown_select) begin
          next_st.fsm = CAL_CONV;
          next_st.start = 1'b1;
        end
      end
      CAL_WAIT: begin
        if (tick) begin
          if (st.ms_cnt == 14'h0001) begin
            next_st.fsm = CAL_CONV;
            next_st.start = 1'b1;
          end else begin
            next_st.ms_cnt = st.ms_cnt - 14'h0001;
          end
        end
      end
      CAL_CONV: begin
        if (conv_done) begin
          if (st.shutdown_select) begin
            next_st.fsm = CAL_IDLE;
          end else begin
            next_st.fsm = CAL_WAIT;
            // Full period of ticks from the end of conversion
            next_st.ms_cnt = period_ms(st.rate_select);
          end
        end
      end
      default: next_st.fsm = CAL_IDLE;
    endcase
    if (cfg_write) begin
      next_st.rate_select = hwdata[RATE_LSB +: 3];
      next_st.shutdown_select = hwdata[SHUT_BIT];
      next_st.ch1_mode_select = hwdata[CH1_MODE_BIT];
      next_st.ch1_output_polarity = hwdata[CH1_POL_BIT];
      next_st.ch2_mode_select = hwdata[CH2_MODE_BIT];
      next_st.ch2_output_polarity = hwdata[CH2_POL_BIT];
      // Abort, and restart unless the new settings are shutdown without single-shot
      if (!hwdata[SHUT_BIT] || hwdata[SINGLE_BIT]) begin
        next_st.fsm = CAL_CONV;
        next_st.start = 1'b1;
      end else begin
        next_st.fsm = CAL_IDLE;
        // A tick start in this cycle must not leak into shutdown
        next_st.start = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st <= '{fsm: CAL_IDLE, rate_select: RATE_RESET, shutdown_select: 1'b0,
              ch1_mode_select: 1'b0, ch1_output_polarity: 1'b0,
              ch2_mode_select: 1'b0, ch2_output_polarity: 1'b0,
              high1: HIGH_RESET, low1: LOW_RESET, high2: HIGH_RESET, low2: LOW_RESET,
              temp: 14'h0000, tick_cnt: 17'h00000, ms_cnt: 14'h0000,
              ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00, rdata: 32'h0000_0000,
              start: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  cal_limit_channel u_ch1 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode_select(st.ch1_mode_select),
    .output_polarity(st.ch1_output_polarity),
    .high_limit(st.high1),
    .low_limit(st.low1),
    .result_valid(result_valid),
    .result(conv_result),
    .flag_read(cfg_read),
    .high_flag(ch1_high_flag),
    .low_flag(ch1_low_flag),
    .warning_output(first_warning_output)
  );

  cal_limit_channel u_ch2 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mode_select(st.ch2_mode_select),
    .output_polarity(st.ch2_output_polarity),
    .high_limit(st.high2),
    .low_limit(st.low2),
    .result_valid(result_valid),
    .result(conv_result),
    .flag_read(cfg_read),
    .high_flag(ch2_high_flag),
    .low_flag(ch2_low_flag),
    .warning_output(second_warning_output)
  );

  // Zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign conv_start = st.start;
endmodule

// ---- verification/cal_control_assertions.sv ----
// Port-level checker for the conversion and alert control block
`timescale 1ns/10ps
module cal_control_checker #(
  parameter int unsigned TICK_LEN = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Converter and pins
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic first_warning_output,
  input wire logic second_warning_output
);
  import cal_pkg::*;
  logic acc, wr, rd, shut, ev;
  assign acc = hsel && hready && htrans[1];
  assign ev = conv_done || wr || acc;
  // Data-phase markers for configuration accesses
  always_ff @(posedge sys_clk) begin
    wr <= rst_b && acc && hwrite && haddr == ADDR_CONFIG;
    rd <= rst_b && acc && !hwrite && haddr == ADDR_CONFIG;
    if (!rst_b) shut <= 1'b0;
    else if (wr) shut <= hwdata[SHUT_BIT] && !hwdata[SINGLE_BIT];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_restart; wr && !hwdata[SHUT_BIT] |-> ##[1:2] conv_start; endproperty
  a_restart: assert property (p_restart) else $error("write did not restart");
  property p_shot; wr && hwdata[SHUT_BIT] && hwdata[SINGLE_BIT] |-> ##[1:2] conv_start; endproperty
  a_shot: assert property (p_shot) else $error("single shot not started");
  // One cycle of grace: a start may already be in flight at the write edge
  property p_shut_quiet; shut && $past(shut) |-> !conv_start; endproperty
  a_shut_quiet: assert property (p_shut_quiet) else $error("start in shutdown");
  property p_os_zero; rd |-> hrdata[SINGLE_BIT] == 1'b0; endproperty
  a_os_zero: assert property (p_os_zero) else $error("single shot bit read 1");
  property p_rate_gap; conv_done && !wr && !$past(wr) |=> !conv_start [*2]; endproperty
  a_rate_gap: assert property (p_rate_gap) else $error("restart right after done");
  property p_pin1; !$stable(first_warning_output) |-> $past(ev) || $past(ev, 2); endproperty
  a_pin1: assert property (p_pin1) else $error("first pin moved alone");
  property p_pin2; !$stable(second_warning_output) |-> $past(ev) || $past(ev, 2); endproperty
  a_pin2: assert property (p_pin2) else $error("second pin moved alone");
  c_done: cover property (conv_done);
  c_rd: cover property (rd);
  c_pin: cover property ($fell(first_warning_output));
endmodule

bind cal_control cal_control_checker #(.TICK_LEN(TICK_LEN)) i_cal_control_checker (
  .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .conv_start(conv_start), .conv_done(conv_done),
  .first_warning_output(first_warning_output), .second_warning_output(second_warning_output));

// ---- verification/test_conversion_and_limit_alert_control.sv ----
// Self-checking bench for the conversion and alert control block
`timescale 1ns/10ps
module test_conversion_and_limit_alert_control;
  import cal_pkg::*;
  typedef struct {
    logic [15:0] cfg;
    logic [13:0] res;
    logic [15:0] rd1;
    logic [15:0] rd2;
    logic [1:0] pins;
  } cal_row_t;
  // Short tick keeps the slow rates affordable
  localparam int TL = 10;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic conv_done = 1'b0;
  logic [13:0] conv_result = 14'h0;
  logic [31:0] hrdata, rdv;
  logic hready, hreadyout, hresp, conv_start, first_warning_output, second_warning_output;
  int fail_count = 0;
  int n_compared = 0;
  int n, m;
  int per[8] = '{15, 50, 100, 250, 500, 1000, 4000, 16000};
  cal_row_t rows[10];
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;
  cal_control #(.TICK_LEN(TL)) i_cal_control (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .first_warning_output(first_warning_output),
    .second_warning_output(second_warning_output));
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    wrap_up;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t count %0d", $time, got);
    end
  endtask
  task automatic chk_pins(input logic [1:0] e);
    chk({30'h0, first_warning_output, second_warning_output}, {30'h0, e});
  endtask
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) hang;
      @(posedge sys_clk);
    end
  endtask
  // Address phase held until ready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy;
    rdv = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic wait_start;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20000) hang;
    end while (conv_start !== 1'b1);
  endtask
  task automatic conv(input logic [13:0] r);
    wait_start;
    conv_done <= 1'b1;
    conv_result <= r;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic quiet;
    m = 0;
    repeat (300) begin
      @(posedge sys_clk);
      if (conv_start === 1'b1) m++;
    end
    chk_cnt(m, 0, 0);
  endtask
  initial begin
    rows = '{'{16'h0000, 14'h00c8, 16'h0440, 16'h0000, 2'b00}, '{16'h0000, 14'h3f38, 16'h0220, 16'h0000, 2'b00},
      '{16'h0088, 14'h004b, 16'h00c8, 16'h0088, 2'b01}, '{16'h0110, 14'h004b, 16'h0150, 16'h0150, 2'b10},
      '{16'h0110, 14'h0000, 16'h0150, 16'h0150, 2'b10}, '{16'h0110, 14'h3f38, 16'h0110, 16'h0110, 2'b11},
      '{16'h0110, 14'h0065, 16'h0550, 16'h0550, 2'b00}, '{16'h0110, 14'h3f38, 16'h0110, 16'h0110, 2'b11},
      '{16'h0000, 14'h0064, 16'h0040, 16'h0000, 2'b10}, '{16'h0000, 14'h3f9c, 16'h0020, 16'h0000, 2'b10}};
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk_pins(2'b11);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    rdc(ADDR_CONFIG, 32'ha000);
    rdc(ADDR_HIGH1, 32'h7ffc);
    rdc(8'h18, 32'h0);
    bus(1'b1, ADDR_HIGH1, 32'h0190);
    bus(1'b1, ADDR_LOW1, 32'hfe70);
    bus(1'b1, ADDR_HIGH2, 32'h00c8);
    bus(1'b1, ADDR_LOW2, 32'hff38);
    rdc(ADDR_LOW1, 32'hfe70);
    foreach (rows[i]) begin
      bus(1'b1, ADDR_CONFIG, {16'h0, rows[i].cfg});
      conv(rows[i].res);
      chk_pins(rows[i].pins);
      rdc(ADDR_TEMP, {16'h0, rows[i].res, 2'b00});
      rdc(ADDR_CONFIG, {16'h0, rows[i].rd1});
      rdc(ADDR_CONFIG, {16'h0, rows[i].rd2});
    end
    // Result landing in the aborting write's data phase is dropped
    bus(1'b1, ADDR_CONFIG, 32'h0);
    wait_start;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ADDR_CONFIG;
    hwrite <= 1'b1;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'h0;
    conv_done <= 1'b1;
    conv_result <= 14'h00c8;
    edge_rdy;
    conv_done <= 1'b0;
    rdc(ADDR_CONFIG, 32'h0);
    rdc(ADDR_TEMP, 32'hfe70);
    bus(1'b1, ADDR_CONFIG, 32'h0800);
    quiet;
    bus(1'b1, ADDR_CONFIG, 32'hf800);
    conv(14'h0);
    quiet;
    rdc(ADDR_CONFIG, 32'he800);
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, ADDR_CONFIG, 32'(c) << RATE_LSB);
      conv(14'h0);
      wait_start;
      chk_cnt(n + 2, (per[c] - 1) * TL, per[c] * TL + 3);
    end
    // Reset in mid-conversion brings back the defaults
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_start;
    chk_pins(2'b11);
    rdc(ADDR_CONFIG, 32'ha000);
    rdc(ADDR_TEMP, 32'h0);
    rdc(ADDR_LOW1, 32'h8000);
    wrap_up;
  end
endmodule
